// [inc/prst_pkg.sv]
// package of the page request status tracker: offsets, bit positions, reset values, states
// assumes a 32-bit register port with byte offsets on an 8-bit address
package prst_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int INT_W = 3;
  localparam int CODE_W = 4;
  localparam int PASID_W = 20;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CAPACITY = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ALLOC = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_INT_CLEAR = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_INT_ENABLE = 8'h18;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int ST_RF_BIT = 0;
  localparam int ST_UNM_BIT = 1;
  localparam int ST_STOP_BIT = 8;
  localparam int INT_RF_BIT = 0;
  localparam int INT_UNM_BIT = 1;
  localparam int INT_STOP_BIT = 2;

  // values
  localparam logic [CODE_W-1:0] FAIL_CODE = 4'hf;
  localparam logic [DATA_W-1:0] ALLOC_RESET = 32'h0;
  localparam logic [DATA_W-1:0] CAPACITY_DEFAULT = 32'h00000020;
  localparam logic [INT_W-1:0] INT_EN_RESET = 3'h0;

  typedef enum logic [2:0] {
    ST_ENABLED = 3'b001,
    ST_STOPPING = 3'b010,
    ST_DISABLED = 3'b100
  } prst_state_e;
endpackage

// [inc/prst_track_if.sv]
// interface between the tracker top and its outstanding group table
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface prst_track_if #(parameter int IDX_W = 4) ();
  logic issue;
  logic [IDX_W-1:0] issueIdx;
  logic rspValid;
  logic rspIsGroup;
  logic [IDX_W-1:0] rspIdx;
  logic [prst_pkg::CODE_W-1:0] rspCode;
  logic flush;
  logic matched;
  logic unmatched;
  logic failed;
  logic anyOutstanding;
  modport tracker (
    input issue, issueIdx, rspValid, rspIsGroup, rspIdx, rspCode, flush,
    output matched, unmatched, failed, anyOutstanding
  );
  modport owner (
    output issue, issueIdx, rspValid, rspIsGroup, rspIdx, rspCode, flush,
    input matched, unmatched, failed, anyOutstanding
  );
endinterface // prst_track_if

// [hdl/prst_sticky.sv]
// sticky flag bank: set wins over write-one clear and over bulk clear
// assumes set, clr and flush are single-cycle or level, synchronous to ref_clk
`timescale 1ns/10ps
module prst_sticky #(parameter int W = 2) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  input wire logic flush,
  output logic [W-1:0] q
);
  logic [W-1:0] flag_q;
  logic [W-1:0] flag_d;

  // next value per bit, set has priority
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign flag_d[i] = set[i] | (flag_q[i] & ~clr[i] & ~flush);
    end
  endgenerate

  // flag storage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign q = flag_q;
endmodule // prst_sticky

// [hdl/prst_group_tracker.sv]
// table of outstanding page request groups and response classification
// assumes the owner gates away responses that are to be ignored
`timescale 1ns/10ps
module prst_group_tracker #(parameter int IDX_W = 4) (
  input wire logic ref_clk,
  input wire logic rstn,
  prst_track_if.tracker trk
);
  localparam int N = 2 ** IDX_W;
  logic [N-1:0] pend_q;
  logic [N-1:0] pend_d;
  logic hit;

  // classify the response in flight
  assign hit = pend_q[trk.rspIdx];
  assign trk.matched = trk.rspValid & trk.rspIsGroup & hit;
  assign trk.unmatched = trk.rspValid & trk.rspIsGroup & ~hit;
  assign trk.failed = trk.rspValid & (trk.rspCode == prst_pkg::FAIL_CODE);
  assign trk.anyOutstanding = |pend_q;

  // per group: issue sets, matching response retires, flush empties
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_grp
      assign pend_d[i] = ~trk.flush & ((trk.issue & (trk.issueIdx == IDX_W'(i)))
                         | (pend_q[i] & ~(trk.matched & (trk.rspIdx == IDX_W'(i)))));
    end
  endgenerate

  // table storage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // an unmatched response leaves the table untouched
  property p_discard;
    @(posedge ref_clk) disable iff (!rstn)
      (trk.unmatched && !trk.issue && !trk.flush) |=> (pend_q == $past(pend_q));
  endproperty
  a_discard: assert property (p_discard) else $error("unmatched response changed table");
endmodule // prst_group_tracker

// [hdl/prst_status_top.sv]
// page request status tracking: control, status, capacity, allocation and interrupt registers
// assumes a single-cycle strobe register port and responses synchronous to ref_clk
//
// Overview of operation
// - stopped means no new requests, none outstanding
// - stopped only meaningful while enable clear
// - enable falling enters stopping, clears stopped
// - all responses received: set stopped, disabled
// - nothing outstanding: stopped set immediately
// - interface reset goes straight to disabled
// - failure while stopping: disabled, stopped set
// - stopped set on idle enable fall, cleared rise
// - unmatched group index sets flag, discards
// - enable rising clears unmatched flag
// - failure code sets response failure flag
// - failure terminates context, later responses ignored
// - enable rising clears response failure flag
// - flags clear by writing one or on enable rising
// - read-only capacity value, otherwise unused
// - allocation resets zero and accepts writes
// - control bit zero enables page requests
`timescale 1ns/10ps
module prst_status_top #(
  parameter logic [31:0] CAPACITY = prst_pkg::CAPACITY_DEFAULT,
  parameter int IDX_W = 4
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [prst_pkg::ADDR_W-1:0] regAddr,
  input wire logic [prst_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [prst_pkg::DATA_W-1:0] regRdData,
  input wire logic reqIssue,
  input wire logic [IDX_W-1:0] reqIndex,
  output logic reqAllowed,
  input wire logic rspValid,
  input wire logic rspIsGroup,
  input wire logic [IDX_W-1:0] rspIndex,
  input wire logic [prst_pkg::CODE_W-1:0] rspCode,
  input wire logic [prst_pkg::PASID_W-1:0] rspPasid,
  output logic ctxTermValid,
  output logic [prst_pkg::PASID_W-1:0] ctxTermPasid,
  output logic irq
);
  prst_pkg::prst_state_e state_q;
  prst_pkg::prst_state_e state_d;
  logic enable_q;
  logic stopped_q;
  logic stopped_d;
  logic failLock_q;
  logic [prst_pkg::DATA_W-1:0] alloc_q;
  logic [prst_pkg::DATA_W-1:0] rdData_q;
  logic [prst_pkg::DATA_W-1:0] rdNext;
  logic [prst_pkg::INT_W-1:0] intEn_q;
  logic [prst_pkg::INT_W-1:0] intSt;
  logic [prst_pkg::INT_W-1:0] intSet;
  logic [prst_pkg::INT_W-1:0] intClr;
  logic ctxTermValid_q;
  logic [prst_pkg::PASID_W-1:0] ctxTermPasid_q;
  logic [1:0] flagSet;
  logic [1:0] flagClr;
  logic [1:0] flags;
  logic wrCtrl;
  logic wrStatus;
  logic wrAlloc;
  logic wrIntClr;
  logic wrIntEn;
  logic enRise;
  logic enFall;
  logic ifReset;
  logic enterDisabled;
  logic stopSet;
  logic [15:0] statusWord;

  prst_track_if #(.IDX_W(IDX_W)) trk ();

  // write decode for one register offset
  function automatic logic wrHit(input logic [prst_pkg::ADDR_W-1:0] a, input logic [prst_pkg::ADDR_W-1:0] off,
                                 input logic we);
    wrHit = we && (a == off);
  endfunction

  // register write decode
  assign wrCtrl = wrHit(regAddr, prst_pkg::OFF_CTRL, regWrEn);
  assign wrStatus = wrHit(regAddr, prst_pkg::OFF_STATUS, regWrEn);
  assign wrAlloc = wrHit(regAddr, prst_pkg::OFF_ALLOC, regWrEn);
  assign wrIntClr = wrHit(regAddr, prst_pkg::OFF_INT_CLEAR, regWrEn);
  assign wrIntEn = wrHit(regAddr, prst_pkg::OFF_INT_ENABLE, regWrEn);

  // enable edges and interface reset request
  assign enRise = wrCtrl && regWrData[prst_pkg::CTRL_EN_BIT] && !enable_q;
  assign enFall = wrCtrl && !regWrData[prst_pkg::CTRL_EN_BIT] && enable_q;
  assign ifReset = wrCtrl && regWrData[prst_pkg::CTRL_RST_BIT] && !regWrData[prst_pkg::CTRL_EN_BIT];

  // requests only leave while enabled and running
  assign reqAllowed = (state_q == prst_pkg::ST_ENABLED);

  // feed the outstanding table; responses are dropped after a failure
  assign trk.issue = reqIssue && reqAllowed;
  assign trk.issueIdx = reqIndex;
  assign trk.rspValid = rspValid && !failLock_q;
  assign trk.rspIsGroup = rspIsGroup;
  assign trk.rspIdx = rspIndex;
  assign trk.rspCode = rspCode;
  assign trk.flush = ifReset;

  prst_group_tracker #(.IDX_W(IDX_W)) u_tracker (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .trk(trk)
  );

  // interface state sequencing
  always_comb begin
    state_d = state_q;
    if (ifReset) begin
      state_d = prst_pkg::ST_DISABLED;
    end else begin
      case (state_q)
        prst_pkg::ST_ENABLED: begin
          // a request taken beside the fall must still drain
          if (enFall) begin
            state_d = (trk.anyOutstanding || trk.issue) ? prst_pkg::ST_STOPPING
                                                        : prst_pkg::ST_DISABLED;
          end
        end
        prst_pkg::ST_STOPPING: begin
          if (enRise) begin
            state_d = prst_pkg::ST_ENABLED;
          end else if (trk.failed || !trk.anyOutstanding) begin
            state_d = prst_pkg::ST_DISABLED;
          end
        end
        prst_pkg::ST_DISABLED: begin
          if (enRise) begin
            state_d = prst_pkg::ST_ENABLED;
          end
        end
        default: begin
          state_d = prst_pkg::ST_DISABLED;
        end
      endcase
    end
  end

  // stopped bit: set on reaching disabled, cleared on enable rise or stopping entry
  assign enterDisabled = (state_d == prst_pkg::ST_DISABLED) && ((state_q != prst_pkg::ST_DISABLED) || ifReset);
  assign stopSet = enterDisabled;
  assign stopped_d = enRise ? 1'b0 : (enterDisabled ? 1'b1 :
                     ((state_d == prst_pkg::ST_STOPPING) ? 1'b0 : stopped_q));

  // state, enable and stopped storage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= prst_pkg::ST_DISABLED;
      enable_q <= 1'b0;
      stopped_q <= 1'b0;
    end else begin
      state_q <= state_d;
      enable_q <= wrCtrl ? regWrData[prst_pkg::CTRL_EN_BIT] : enable_q;
      stopped_q <= stopped_d;
    end
  end

  // failure lock: further responses ignored until re-enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      failLock_q <= 1'b0;
    end else begin
      failLock_q <= trk.failed | (failLock_q & ~enRise);
    end
  end

  // context termination notice for the failing address space
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctxTermValid_q <= 1'b0;
      ctxTermPasid_q <= '0;
    end else begin
      ctxTermValid_q <= trk.failed;
      ctxTermPasid_q <= trk.failed ? rspPasid : ctxTermPasid_q;
    end
  end
  assign ctxTermValid = ctxTermValid_q;
  assign ctxTermPasid = ctxTermPasid_q;

  // status flags: bit 0 failure, bit 1 unmatched index
  assign flagSet[prst_pkg::ST_RF_BIT] = trk.failed;
  assign flagSet[prst_pkg::ST_UNM_BIT] = trk.unmatched;
  assign flagClr = wrStatus ? regWrData[1:0] : 2'h0;

  prst_sticky #(.W(2)) u_flags (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set(flagSet),
    .clr(flagClr),
    .flush(enRise),
    .q(flags)
  );

  // interrupt events and write-one clear
  assign intSet = {stopSet, trk.unmatched, trk.failed};
  assign intClr = wrIntClr ? regWrData[prst_pkg::INT_W-1:0] : '0;

  prst_sticky #(.W(prst_pkg::INT_W)) u_int (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set(intSet),
    .clr(intClr),
    .flush(1'b0),
    .q(intSt)
  );
  assign irq = |(intSt & intEn_q);

  // allocation and interrupt enable storage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      alloc_q <= prst_pkg::ALLOC_RESET;
      intEn_q <= prst_pkg::INT_EN_RESET;
    end else begin
      alloc_q <= wrAlloc ? regWrData : alloc_q;
      intEn_q <= wrIntEn ? regWrData[prst_pkg::INT_W-1:0] : intEn_q;
    end
  end

  // status word, reserved bits zero
  assign statusWord = {7'h00, stopped_q, 6'h00, flags[prst_pkg::ST_UNM_BIT], flags[prst_pkg::ST_RF_BIT]};

  // read selection
  assign rdNext = (regAddr == prst_pkg::OFF_CTRL) ? {31'h0, enable_q} :
                  (regAddr == prst_pkg::OFF_STATUS) ? {16'h0000, statusWord} :
                  (regAddr == prst_pkg::OFF_CAPACITY) ? CAPACITY :
                  (regAddr == prst_pkg::OFF_ALLOC) ? alloc_q :
                  (regAddr == prst_pkg::OFF_INT_STATUS) ? {29'h0, intSt} :
                  (regAddr == prst_pkg::OFF_INT_ENABLE) ? {29'h0, intEn_q} : 32'h0;

  // read data only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= '0;
    end else begin
      rdData_q <= regRdEn ? rdNext : 32'h0;
    end
  end
  assign regRdData = rdData_q;

  // checks
  sequence s_fall_busy;
    (state_q == prst_pkg::ST_ENABLED) && enFall && trk.anyOutstanding && !ifReset;
  endsequence
  sequence s_now_stopping;
    (state_q == prst_pkg::ST_STOPPING) && !stopped_q;
  endsequence

  // only a failure while stopping may leave groups behind
  property p_stop_clean;
    @(posedge ref_clk) disable iff (!rstn) stopped_q |-> !reqAllowed && (!trk.anyOutstanding || failLock_q);
  endproperty
  a_stop_clean: assert property (p_stop_clean) else $error("stopped with requests outstanding");

  property p_enter_stopping;
    @(posedge ref_clk) disable iff (!rstn) s_fall_busy |=> s_now_stopping;
  endproperty
  a_enter_stopping: assert property (p_enter_stopping) else $error("enable fall did not enter stopping");

  property p_stop_done;
    @(posedge ref_clk) disable iff (!rstn)
      ((state_q == prst_pkg::ST_STOPPING) && !trk.anyOutstanding && !enRise && !ifReset)
      |=> (state_q == prst_pkg::ST_DISABLED) && stopped_q;
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("drained stopping did not disable");

  property p_fall_idle;
    @(posedge ref_clk) disable iff (!rstn)
      ((state_q == prst_pkg::ST_ENABLED) && enFall && !trk.anyOutstanding && !trk.issue)
      |=> (state_q == prst_pkg::ST_DISABLED) && stopped_q;
  endproperty
  a_fall_idle: assert property (p_fall_idle) else $error("idle fall did not stop at once");

  property p_fall_race;
    @(posedge ref_clk) disable iff (!rstn)
      ((state_q == prst_pkg::ST_ENABLED) && enFall && trk.issue && !ifReset) |=> s_now_stopping;
  endproperty
  a_fall_race: assert property (p_fall_race) else $error("request beside enable fall was dropped");

  property p_if_reset;
    @(posedge ref_clk) disable iff (!rstn)
      ifReset |=> (state_q == prst_pkg::ST_DISABLED) && stopped_q && !trk.anyOutstanding;
  endproperty
  a_if_reset: assert property (p_if_reset) else $error("interface reset did not disable");

  property p_fail_stop;
    @(posedge ref_clk) disable iff (!rstn)
      ((state_q == prst_pkg::ST_STOPPING) && trk.failed && !enRise) |=> (state_q == prst_pkg::ST_DISABLED) && stopped_q;
  endproperty
  a_fail_stop: assert property (p_fail_stop) else $error("failure while stopping did not disable");

  property p_rise_clears;
    @(posedge ref_clk) disable iff (!rstn)
      (enRise && !trk.failed && !trk.unmatched) |=> !stopped_q && (flags == 2'h0) && reqAllowed;
  endproperty
  a_rise_clears: assert property (p_rise_clears) else $error("enable rise did not clear status");

  property p_unmatched;
    @(posedge ref_clk) disable iff (!rstn) trk.unmatched |=> flags[prst_pkg::ST_UNM_BIT] && intSt[prst_pkg::INT_UNM_BIT];
  endproperty
  a_unmatched: assert property (p_unmatched) else $error("unmatched index not flagged");

  property p_fail_flag;
    @(posedge ref_clk) disable iff (!rstn)
      trk.failed |=> flags[prst_pkg::ST_RF_BIT] && ctxTermValid && (ctxTermPasid == $past(rspPasid));
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("failure not flagged or context not ended");

  property p_ignore;
    @(posedge ref_clk) disable iff (!rstn) failLock_q |-> !trk.failed && !trk.unmatched && !trk.matched;
  endproperty
  a_ignore: assert property (p_ignore) else $error("response accepted after failure");

  property p_w0_keeps;
    @(posedge ref_clk) disable iff (!rstn)
      (wrStatus && !regWrData[prst_pkg::ST_RF_BIT] && flags[prst_pkg::ST_RF_BIT] && !enRise) |=> flags[prst_pkg::ST_RF_BIT];
  endproperty
  a_w0_keeps: assert property (p_w0_keeps) else $error("zero write cleared failure flag");

  property p_capacity;
    @(posedge ref_clk) disable iff (!rstn) (regRdEn && (regAddr == prst_pkg::OFF_CAPACITY)) |=> (regRdData == CAPACITY);
  endproperty
  a_capacity: assert property (p_capacity) else $error("capacity read wrong");

  property p_alloc;
    @(posedge ref_clk) disable iff (!rstn) wrAlloc |=> (alloc_q == $past(regWrData));
  endproperty
  a_alloc: assert property (p_alloc) else $error("allocation write lost");

  property p_reserved;
    @(posedge ref_clk) disable iff (!rstn)
      (regRdEn && (regAddr == prst_pkg::OFF_STATUS)) |=> (regRdData[31:9] == 23'h0) && (regRdData[7:2] == 6'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bits not zero");
endmodule // prst_status_top

// [tb/prst_host_model.sv]
// host side model: sends page responses into the tracker, one-cycle pulses
// assumes calls come from the bench; fields are zero until the first response, then show inverted junk while idle
`timescale 1ns/10ps
module prst_host_model #(parameter int IDX_W = 4) (
  input wire logic ref_clk,
  output logic rspValid,
  output logic rspIsGroup,
  output logic [IDX_W-1:0] rspIndex,
  output logic [prst_pkg::CODE_W-1:0] rspCode,
  output logic [prst_pkg::PASID_W-1:0] rspPasid
);
  // idle at time zero
  initial begin
    rspValid = 1'b0;
    rspIsGroup = 1'b0;
    rspIndex = '0;
    rspCode = '0;
    rspPasid = '0;
  end

  // one response, then fields invert so stale values are never trusted
  task automatic send(input logic g, input logic [IDX_W-1:0] idx, input logic [3:0] code,
                      input logic [19:0] pasid);
    @(posedge ref_clk);
    rspValid <= 1'b1;
    rspIsGroup <= g;
    rspIndex <= idx;
    rspCode <= code;
    rspPasid <= pasid;
    @(posedge ref_clk);
    rspValid <= 1'b0;
    rspIsGroup <= ~g;
    rspIndex <= ~idx;
    rspCode <= ~code;
    rspPasid <= ~pasid;
  endtask
endmodule // prst_host_model

// [tb/testbench.sv]
// self-checking bench of the page request status tracker against a queue model
// assumes the host model drives responses and the bench is register master
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [31:0] regRdData;
  logic reqIssue = 1'b0;
  logic [3:0] reqIndex = 4'h0;
  logic reqAllowed, rspValid, rspIsGroup, ctxTermValid, irq;
  logic [3:0] rspIndex, rspCode;
  logic [19:0] rspPasid, ctxTermPasid;
  int err_count = 0;
  int checks_done = 0;
  // model state
  bit mEn, mStop, mRf, mUnm, mLock;
  int mOut[$];
  logic [31:0] rd;
  logic [19:0] pas;
  int qs;

  always #12.5 ref_clk = ~ref_clk;

  prst_status_top #(.CAPACITY(32'h00000020), .IDX_W(4)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .reqIssue(reqIssue),
    .reqIndex(reqIndex), .reqAllowed(reqAllowed), .rspValid(rspValid), .rspIsGroup(rspIsGroup),
    .rspIndex(rspIndex), .rspCode(rspCode), .rspPasid(rspPasid), .ctxTermValid(ctxTermValid),
    .ctxTermPasid(ctxTermPasid), .irq(irq));

  prst_host_model #(.IDX_W(4)) host (
    .ref_clk(ref_clk), .rspValid(rspValid), .rspIsGroup(rspIsGroup), .rspIndex(rspIndex),
    .rspCode(rspCode), .rspPasid(rspPasid));

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask

  // control write with model update
  task automatic ctrl(input logic [31:0] v);
    wr(prst_pkg::OFF_CTRL, v);
    if (v[0] && !mEn) begin
      mEn = 1;
      mStop = 0;
      mRf = 0;
      mUnm = 0;
      mLock = 0;
    end else if (!v[0] && mEn) begin
      mEn = 0;
      if (mOut.size() == 0) mStop = 1;
    end
    if (v[1] && !v[0]) begin
      mOut.delete(); mEn = 0; mStop = 1;
    end
  endtask

  task automatic issue(input logic [3:0] idx);
    @(posedge ref_clk);
    reqIssue <= 1'b1;
    reqIndex <= idx;
    @(posedge ref_clk);
    reqIssue <= 1'b0;
    reqIndex <= ~idx;
    if (mEn) mOut.push_back(idx);
  endtask

  // response through the host model, with expected side effects
  task automatic rsp(input logic g, input logic [3:0] idx, input logic [3:0] code, input logic [19:0] p);
    bit fail;
    int f[$];
    fail = !mLock && code == 4'hf;
    host.send(g, idx, code, p);
    #1 chk(ctxTermValid, fail);
    if (fail) chk(ctxTermPasid, p);
    if (!mLock) begin
      if (fail) begin
        mRf = 1;
        mLock = 1;
        if (!mEn) mStop = 1;
      end
      // a failing group response still retires or misses its group
      if (g) begin
        f = mOut.find_first_index(x) with (x == idx);
        if (f.size() == 0) mUnm = 1;
        else begin
          mOut.delete(f[0]);
          if (!mEn && mOut.size() == 0) mStop = 1;
        end
      end
    end
  endtask

  // status word and request gate against the model
  task automatic chkSt();
    rdr(prst_pkg::OFF_STATUS, rd);
    if (!mEn) chk(rd, {23'h0, mStop, 6'h0, mUnm, mRf});
    else chk(rd & 32'hfffffeff, {30'h0, mUnm, mRf});
    rdr(prst_pkg::OFF_CTRL, rd);
    chk(rd, {31'h0, mEn});
    chk(reqAllowed, mEn);
  endtask

  initial begin
    #(25ns * 20000);
    err_count++;
    test_done();
  end

  initial begin
    void'($urandom(32'ha0e75543));
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    // reset values and read-only places
    chkSt();
    rdr(prst_pkg::OFF_CAPACITY, rd);
    chk(rd, 32'h00000020);
    rdr(prst_pkg::OFF_ALLOC, rd);
    chk(rd, 32'h0);
    rdr(8'h40, rd);
    chk(rd, 32'h0); // unmapped
    wr(prst_pkg::OFF_CAPACITY, 32'hffffffff);
    wr(prst_pkg::OFF_STATUS, 32'hfffffffc);
    rdr(prst_pkg::OFF_CAPACITY, rd);
    chk(rd, 32'h00000020);
    chkSt();
    qs = $urandom_range(0, 12);
    wr(prst_pkg::OFF_ALLOC, 32'h1 << (qs + 8));
    rdr(prst_pkg::OFF_ALLOC, rd);
    chk(rd, 32'h1 << (qs + 8));
    $display("test registers done");
    // stopping with two outstanding groups
    ctrl(32'h1);
    chkSt();
    issue(4'h3);
    issue(4'h5);
    ctrl(32'h0);
    chkSt();
    rsp(1'b1, 4'h3, 4'h0, 20'h0);
    chkSt();
    rsp(1'b1, 4'h5, 4'h0, 20'h0);
    chkSt();
    ctrl(32'h1);
    ctrl(32'h0);
    chkSt();
    ctrl(32'h1);
    chkSt();
    $display("test stopping done");
    // unmatched index, write-one clear, enable-rise clear
    rsp(1'b1, 4'(($urandom_range(0, 15))), 4'h0, 20'h0);
    chkSt();
    wr(prst_pkg::OFF_STATUS, 32'h0);
    chkSt();
    wr(prst_pkg::OFF_STATUS, 32'h2);
    mUnm = 0;
    chkSt();
    rsp(1'b1, 4'h9, 4'h0, 20'h0);
    ctrl(32'h0);
    ctrl(32'h1);
    chkSt();
    $display("test unmatched done");
    // failure while stopping, then responses ignored
    issue(4'h2);
    ctrl(32'h0);
    pas = 20'($urandom());
    rsp(1'b0, 4'h0, prst_pkg::FAIL_CODE, pas);
    chkSt();
    rsp(1'b1, 4'h7, 4'h0, 20'h0);
    rsp(1'b0, 4'h0, 4'hf, ~pas);
    chkSt();
    wr(prst_pkg::OFF_STATUS, 32'h1);
    mRf = 0;
    chkSt();
    ctrl(32'h1);
    rsp(1'b1, 4'h2, prst_pkg::FAIL_CODE, pas);
    ctrl(32'h0);
    ctrl(32'h1);
    chkSt();
    $display("test failure done");
    // interface reset with a group outstanding
    issue(4'h4);
    ctrl(32'h2);
    chkSt();
    ctrl(32'h1);
    $display("test reset done");
    // request beside the enable fall still drains
    fork
      issue(4'h6);
      wr(prst_pkg::OFF_CTRL, 32'h0);
    join
    mEn = 0;
    chkSt();
    rsp(1'b1, 4'h6, 4'h0, 20'h0);
    chkSt();
    ctrl(32'h1);
    $display("test race done");
    // interrupt: clear, enable, raise, mask, clear
    wr(prst_pkg::OFF_INT_CLEAR, 32'h7);
    rdr(prst_pkg::OFF_INT_STATUS, rd);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    wr(prst_pkg::OFF_INT_ENABLE, 32'h2);
    rsp(1'b1, 4'hc, 4'h0, 20'h0);
    rdr(prst_pkg::OFF_INT_STATUS, rd);
    chk(rd, 32'h2);
    chk(irq, 1'b1);
    wr(prst_pkg::OFF_INT_ENABLE, 32'h5);
    #1 chk(irq, 1'b0);
    wr(prst_pkg::OFF_INT_ENABLE, 32'h2);
    #1 chk(irq, 1'b1);
    wr(prst_pkg::OFF_INT_CLEAR, 32'h2);
    #1 chk(irq, 1'b0);
    $display("test interrupt done");
    test_done();
  end
endmodule // testbench
